/* design/hfc_pkg.sv */
// shared constants, carriers and state codes for the host fifo control
`default_nettype none
package hfc_pkg;
  localparam int DATA_W = 32;
  localparam int RX_DATA_DEPTH = 32;
  localparam int RX_STAT_DEPTH = 16;
  localparam int LEN_W = 11;
  localparam int PKT_LEN_LSB = 0;
  localparam int OFFSET_W = 5;
  localparam int BURST_W = 5;
  localparam logic TX_ON_RST = 1'b0;
  localparam logic [DATA_W-1:0] PAD_WORD = 32'h0;

  typedef struct packed {
    logic last;
    logic [DATA_W-1:0] data;
  } hfc_rx_word_t;

  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic [DATA_W-1:0] cmd_b;
    logic [LEN_W-1:0] buf_bytes;
  } hfc_tx_cmd_t;

  typedef enum logic [2:0] {
    TX_OFF = 3'b001,
    TX_RUN = 3'b010,
    TX_STOP = 3'b100
  } hfc_tx_state_t;

  typedef enum logic [5:0] {
    RX_IDLE = 6'b000001,
    RX_OFFSET = 6'b000010,
    RX_DATA = 6'b000100,
    RX_TAIL = 6'b001000,
    RX_PAD = 6'b010000,
    RX_SKIP = 6'b100000
  } hfc_rx_state_t;
endpackage
`default_nettype wire

/* design/hfc_fifo.sv */
// synchronous fifo with valid/ready on both sides and registered flags
`default_nettype none
module hfc_fifo
  import hfc_pkg::*;
#(
  parameter int WIDTH = 33,
  parameter int DEPTH = 32,
  localparam int AW = $clog2(DEPTH),
  localparam int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  output logic [CW-1:0] count
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  wire logic push = in_valid & in_ready;
  wire logic pop = out_valid & out_ready;
  wire logic [CW-1:0] next_count = CW'(count + CW'(push) - CW'(pop));
  wire logic [AW-1:0] wp_inc = (wp == AW'(DEPTH - 1)) ? '0 : AW'(wp + 1'b1);
  wire logic [AW-1:0] rp_inc = (rp == AW'(DEPTH - 1)) ? '0 : AW'(rp + 1'b1);

  assign out_data = mem[rp];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else if (flush) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) wp <= wp_inc;
      if (pop) rp <= rp_inc;
      count <= next_count;
      in_ready <= next_count != CW'(DEPTH);
      out_valid <= next_count != '0;
    end
  end
endmodule
`default_nettype wire

/* design/hfc_tx_check.sv */
// transmit command consistency checker: length sum and repeated b word
`default_nettype none
module hfc_tx_check
  import hfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire hfc_tx_cmd_t cmd,
  output logic err
);
  logic [LEN_W-1:0] sum;
  logic [DATA_W-1:0] b_ref;
  wire logic [LEN_W-1:0] base = cmd.first ? '0 : sum;
  wire logic [LEN_W-1:0] total = LEN_W'(base + cmd.buf_bytes);
  wire logic [DATA_W-1:0] b_use = cmd.first ? cmd.cmd_b : b_ref;
  wire logic [LEN_W-1:0] pkt_len = b_use[PKT_LEN_LSB +: LEN_W];
  wire logic b_bad = ~cmd.first & (cmd.cmd_b != b_ref); // RULE3
  wire logic len_bad = cmd.last & (total != pkt_len); // RULE1

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum <= '0;
      b_ref <= '0;
      err <= 1'b0;
    end else begin
      err <= cmd.valid & (b_bad | len_bad);
      if (cmd.valid) begin
        sum <= total;
        b_ref <= b_use;
      end
    end
  end
endmodule
`default_nettype wire

/* design/hfc_top.sv */
// host fifo control: tx error flag, tx halt/restart, rx fifos and shaping
// Behaviour
// RULE1: supplied byte count unequal to command packet length sets error flag.
// RULE2: host gives both command words per buffer; second word never changes.
// RULE3: unequal second command words within one packet set error flag.
// RULE4: host write into full transmit data fifo sets error flag.
// RULE5: status fifo overrun sets error flag unless discard option enabled.
// RULE6: error flag never halts the transmitter.
// RULE7: halt request lets current frame finish before stopping.
// RULE8: on final status clear halt and enable bits, pulse halted irq.
// RULE9: restart by enable bit; frames still queued go out first.
// RULE10: packet data goes to data fifo, then status into status fifo.
// RULE11: queued data and status counts are readable at any time.
// RULE12: host never reads more words than reported available.
// RULE13: read underrun raises receive error irq until soft reset.
// RULE14: each packet start shifted by programmable 0..31 byte offset.
// RULE15: host changes offset only between packets.
// RULE16: optional pad words make each packet a whole burst multiple.
// RULE17: offset and padding applied per packet in a continuous stream.
// RULE18: host reads status, then length plus offset plus pad words.
// RULE19: skip bit discards head packet, also while receiver runs.
// RULE20: host skips only packets of at least four words.
// RULE21: skip bit self clears; status fifo untouched by skip.
// RULE22: flush after receiver stop resets both rx fifos, bit self clears.
// RULE23: transmission suspended while transmit status fifo full.
// RULE24: with discard option keep sending, write no status while full.
`default_nettype none
module hfc_top
  import hfc_pkg::*;
#(
  parameter int RX_DEPTH = RX_DATA_DEPTH,
  parameter int ST_DEPTH = RX_STAT_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic soft_reset,
  input wire hfc_tx_cmd_t tx_cmd,
  input wire logic tx_data_wr,
  input wire logic [LEN_W-1:0] tx_data_free,
  input wire logic tx_error_clr,
  input wire logic status_discard_on_overrun,
  input wire logic tx_status_push,
  input wire logic tx_status_full,
  input wire logic tx_frame_busy,
  input wire logic tx_halt_set,
  input wire logic tx_on_set,
  output logic tx_error_flag,
  output logic tx_on,
  output logic tx_halt_req,
  output logic tx_halted_irq,
  output logic tx_mac_go,
  output logic tx_status_wr,
  input wire logic rx_mac_data_valid,
  input wire hfc_rx_word_t rx_mac_data,
  output logic rx_mac_data_ready,
  input wire logic rx_mac_stat_valid,
  input wire logic [DATA_W-1:0] rx_mac_stat,
  output logic rx_mac_stat_ready,
  input wire logic rx_data_rd,
  output logic [DATA_W-1:0] rx_data_out,
  input wire logic rx_stat_rd,
  output logic [DATA_W-1:0] rx_stat_out,
  output logic [$clog2(RX_DEPTH+1)-1:0] rx_data_used,
  output logic [$clog2(ST_DEPTH+1)-1:0] rx_stat_used,
  output logic rx_error_irq,
  input wire logic [OFFSET_W-1:0] rx_offset,
  input wire logic rx_pad_enable,
  input wire logic [BURST_W-1:0] rx_burst_words,
  input wire logic rx_skip_set,
  output logic rx_skip_packet,
  input wire logic rx_flush_set,
  output logic rx_flush_busy
);
  //////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_q;
  logic rst_n_s;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_q <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_q <= 1'b1;
      rst_n_s <= rst_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transmit errors
  logic cmd_err;

  hfc_tx_check u_chk (
    .clk(clk),
    .rst_n(rst_n_s),
    .cmd(tx_cmd),
    .err(cmd_err)
  );

  wire logic data_ovr = tx_data_wr & (tx_data_free == '0); // RULE4
  wire logic stat_full_push = tx_status_push & tx_status_full;
  wire logic stat_ovr = stat_full_push & ~status_discard_on_overrun; // RULE5
  wire logic err_set = cmd_err | data_ovr | stat_ovr;
  // set wins over a clear in the same cycle
  wire logic next_err = err_set | (tx_error_flag & ~tx_error_clr);

  //////////////////////////////////////////////////////////////////////////
  // transmit halt and restart
  hfc_tx_state_t tx_state;
  hfc_tx_state_t next_tx_state;
  logic halt_done;
  wire logic suspend = tx_status_full & ~status_discard_on_overrun; // RULE23

  // error flag is not an input here, so errors never stop sending
  always_comb begin // RULE6
    next_tx_state = tx_state;
    halt_done = 1'b0;
    case (tx_state)
      TX_OFF: begin
        if (tx_on_set) next_tx_state = TX_RUN; // RULE9
      end
      TX_RUN: begin
        if (tx_halt_set && tx_frame_busy) begin
          next_tx_state = TX_STOP; // RULE7
        end else if (tx_halt_set) begin
          next_tx_state = TX_OFF;
          halt_done = 1'b1;
        end
      end
      TX_STOP: begin
        if (tx_status_push) begin
          next_tx_state = TX_OFF; // RULE8
          halt_done = 1'b1;
        end
      end
      default: next_tx_state = TX_OFF;
    endcase
  end

  wire logic next_run = next_tx_state == TX_RUN;
  wire logic next_drain = (next_tx_state == TX_STOP) & tx_frame_busy;
  wire logic next_go = (next_run | next_drain) & ~suspend; // RULE23

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      tx_state <= TX_OFF;
      tx_on <= TX_ON_RST;
      tx_halt_req <= 1'b0;
      tx_halted_irq <= 1'b0;
      tx_mac_go <= 1'b0;
      tx_status_wr <= 1'b0;
      tx_error_flag <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      tx_on <= next_tx_state != TX_OFF; // RULE8
      tx_halt_req <= next_tx_state == TX_STOP;
      tx_halted_irq <= halt_done; // RULE8
      tx_mac_go <= next_go;
      tx_status_wr <= tx_status_push & ~tx_status_full; // RULE24
      tx_error_flag <= next_err; // RULE1 RULE3 RULE4 RULE5
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // receive fifos
  logic df_valid;
  hfc_rx_word_t dw;
  logic sf_ready;
  logic sf_valid;
  logic [DATA_W-1:0] sw;
  logic [$clog2(RX_DEPTH+1)-1:0] dcount;
  logic [$clog2(ST_DEPTH+1)-1:0] scount;
  logic pop;
  logic pkt_open;
  wire logic fifo_clr = rx_flush_busy | soft_reset; // RULE22

  hfc_fifo #(
    .WIDTH($bits(hfc_rx_word_t)),
    .DEPTH(RX_DEPTH)
  ) u_dfifo (
    .clk(clk),
    .rst_n(rst_n_s),
    .flush(fifo_clr),
    .in_valid(rx_mac_data_valid),
    .in_data(rx_mac_data),
    .in_ready(rx_mac_data_ready),
    .out_valid(df_valid),
    .out_data(dw),
    .out_ready(pop),
    .count(dcount)
  );

  hfc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(ST_DEPTH)
  ) u_sfifo (
    .clk(clk),
    .rst_n(rst_n_s),
    .flush(fifo_clr),
    .in_valid(rx_mac_stat_valid),
    .in_data(rx_mac_stat),
    .in_ready(sf_ready),
    .out_valid(sf_valid),
    .out_data(sw),
    .out_ready(rx_stat_rd),
    .count(scount)
  );

  // status only taken once the packet's last data word is in
  wire logic dpush = rx_mac_data_valid & rx_mac_data_ready;
  wire logic spush = rx_mac_stat_valid & rx_mac_stat_ready;
  wire logic next_open = dpush ? ~rx_mac_data.last : pkt_open;
  wire logic next_sready = ~spush & sf_ready & ~next_open; // RULE10

  //////////////////////////////////////////////////////////////////////////
  // receive read shaping: offset, realignment, padding, skip
  hfc_rx_state_t rx_state;
  hfc_rx_state_t next_rx_state;
  logic [OFFSET_W-1:0] off_q;
  logic [2:0] word_left;
  logic [DATA_W-1:0] carry;
  logic [BURST_W-1:0] bcnt;
  logic avail;
  logic [DATA_W-1:0] rd_word;

  // offset latched at packet start so a late change cannot tear a packet
  wire logic [2:0] off_words = rx_offset[4:2]; // RULE14
  wire logic [5:0] sh = {1'b0, off_q[1:0], 3'b000};
  wire logic [DATA_W-1:0] shifted = dw.data << sh;
  wire logic [DATA_W-1:0] spill = (sh == 6'h00) ? '0 :
    dw.data >> (6'h20 - sh);
  wire logic [BURST_W-1:0] bcnt_inc = BURST_W'(bcnt + 1'b1);
  wire logic bwrap = bcnt_inc == rx_burst_words;
  wire logic pad_on = rx_pad_enable & (rx_burst_words != '0);
  wire logic pad_more = pad_on & ~bwrap; // RULE16
  wire logic take = rx_data_rd & avail & ~rx_flush_busy;
  wire logic d_under = rx_data_rd & ~avail; // RULE13
  wire logic s_under = rx_stat_rd & ~sf_valid; // RULE13
  wire logic skip_done = (rx_state == RX_SKIP) & df_valid & dw.last;
  wire logic next_skip = rx_skip_set | (rx_skip_packet & ~skip_done);
  wire logic next_irq = d_under | s_under | (rx_error_irq & ~soft_reset);
  wire logic can_skip = rx_skip_packet &
    (rx_state == RX_IDLE || rx_state == RX_OFFSET || rx_state == RX_DATA);

  always_comb begin
    next_rx_state = rx_state;
    avail = 1'b0;
    pop = 1'b0;
    rd_word = PAD_WORD;
    case (rx_state)
      RX_IDLE: begin
        if (df_valid) begin
          next_rx_state = (off_words != 3'h0) ? RX_OFFSET : RX_DATA;
        end
      end
      RX_OFFSET: begin
        avail = 1'b1;
        if (take && word_left == 3'h1) next_rx_state = RX_DATA;
      end
      RX_DATA: begin
        avail = df_valid;
        pop = take;
        rd_word = shifted | carry; // RULE14
        if (take && dw.last) begin
          if (off_q[1:0] != 2'h0) begin
            next_rx_state = RX_TAIL;
          end else begin
            next_rx_state = pad_more ? RX_PAD : RX_IDLE; // RULE17
          end
        end
      end
      RX_TAIL: begin
        avail = 1'b1;
        rd_word = carry;
        if (take) next_rx_state = pad_more ? RX_PAD : RX_IDLE; // RULE17
      end
      RX_PAD: begin
        avail = 1'b1;
        if (take && bwrap) next_rx_state = RX_IDLE; // RULE16
      end
      RX_SKIP: begin
        pop = df_valid; // RULE19
        if (skip_done) next_rx_state = RX_IDLE; // RULE21
      end
      default: next_rx_state = RX_IDLE;
    endcase
    if (can_skip) next_rx_state = RX_SKIP; // RULE19
    if (fifo_clr) begin
      next_rx_state = RX_IDLE; // RULE22
      pop = 1'b0;
    end
  end

  wire logic pkt_start = (rx_state == RX_IDLE) & df_valid;

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      rx_state <= RX_IDLE;
      off_q <= '0;
      word_left <= '0;
      bcnt <= '0;
    end else begin
      rx_state <= next_rx_state;
      if (pkt_start) begin
        off_q <= rx_offset;
        word_left <= off_words;
        bcnt <= '0;
      end else if (take) begin
        word_left <= word_left - 3'h1;
        bcnt <= bwrap ? '0 : bcnt_inc;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      carry <= '0;
    end else if (pkt_start) begin
      carry <= '0;
    end else if (take && rx_state == RX_DATA) begin
      carry <= spill;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // receive outputs and control bits
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pkt_open <= 1'b0;
      rx_mac_stat_ready <= 1'b0;
      rx_data_out <= '0;
      rx_stat_out <= '0;
      rx_data_used <= '0;
      rx_stat_used <= '0;
      rx_error_irq <= 1'b0;
      rx_skip_packet <= 1'b0;
      rx_flush_busy <= 1'b0;
    end else begin
      pkt_open <= fifo_clr ? 1'b0 : next_open;
      rx_mac_stat_ready <= next_sready & ~fifo_clr;
      if (take) rx_data_out <= rd_word;
      if (rx_stat_rd && sf_valid) rx_stat_out <= sw;
      rx_data_used <= dcount; // RULE11
      rx_stat_used <= scount; // RULE11
      rx_error_irq <= next_irq; // RULE13
      rx_skip_packet <= next_skip & ~fifo_clr; // RULE21
      rx_flush_busy <= rx_flush_set & ~rx_flush_busy; // RULE22
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n_s);

  AST_DATA_OVR_ERR: assert property ( // RULE4
    data_ovr |=> tx_error_flag)
    else $error("tx data overrun did not set error flag");

  AST_STAT_OVR_ERR: assert property ( // RULE5
    (stat_full_push && !status_discard_on_overrun) |=> tx_error_flag)
    else $error("tx status overrun did not set error flag");

  AST_ERR_KEEPS_RUN: assert property ( // RULE6
    (tx_state == TX_RUN && !tx_halt_set) |=> tx_on && tx_state == TX_RUN)
    else $error("transmitter left run without halt request");

  AST_HALT_WAITS: assert property ( // RULE7
    (tx_state == TX_STOP && !tx_status_push) |=> tx_halt_req && tx_on)
    else $error("halt finished before frame status");

  AST_HALT_DONE: assert property ( // RULE8
    (tx_state == TX_STOP && tx_status_push)
      |=> tx_halted_irq && !tx_on && !tx_halt_req ##1 !tx_halted_irq)
    else $error("halt completion wrong");

  AST_SUSPEND: assert property ( // RULE23
    suspend |=> !tx_mac_go)
    else $error("sending while status fifo full");

  AST_NO_STAT_WR_FULL: assert property ( // RULE24
    stat_full_push |=> !tx_status_wr)
    else $error("status written into full fifo");

  AST_STAT_AFTER_DATA: assert property ( // RULE10
    rx_mac_stat_ready |-> !pkt_open)
    else $error("status accepted before packet data complete");

  AST_UNDERRUN_IRQ: assert property ( // RULE13
    (d_under || s_under) |=> rx_error_irq [*2] or
      (rx_error_irq ##1 $past(soft_reset)))
    else $error("underrun irq missing or dropped");

  AST_OFFSET_START: assert property ( // RULE14
    (pkt_start && off_words != 3'h0 && !can_skip && !fifo_clr)
      |=> rx_state == RX_OFFSET)
    else $error("offset words not inserted");

  AST_FLUSH_CLEAR: assert property ( // RULE22
    (rx_flush_set && !rx_flush_busy) |=> rx_flush_busy ##1
      (!rx_flush_busy && !rx_skip_packet && rx_state == RX_IDLE))
    else $error("flush did not complete in one cycle");

  COV_HALT: cover property (tx_state == TX_STOP ##[1:50] tx_halted_irq);
  COV_SKIP: cover property (rx_skip_packet ##[1:100] !rx_skip_packet);
  COV_PAD: cover property (rx_state == RX_TAIL ##1 rx_state == RX_PAD);
  COV_UNDER: cover property (d_under ##1 rx_error_irq);
endmodule
`default_nettype wire

/* test/hfc_mac_model.sv */
// far-side mac model: pushes rx packets, sends tx frames and status
`default_nettype none
module hfc_mac_model
  import hfc_pkg::*;
(
  input wire logic clk,
  output logic rx_mac_data_valid,
  output hfc_rx_word_t rx_mac_data,
  input wire logic rx_mac_data_ready,
  output logic rx_mac_stat_valid,
  output logic [DATA_W-1:0] rx_mac_stat,
  input wire logic rx_mac_stat_ready,
  output logic tx_status_push,
  output logic tx_frame_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {rx_mac_data_valid, rx_mac_stat_valid} = 2'h0;
    {tx_status_push, tx_frame_busy} = 2'h0;
    rx_mac_data = '0;
    rx_mac_stat = '0;
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////
  // a released line shows the inverse, so a stale word never matches
  task automatic send_pkt(input int n, input logic [31:0] base,
                          input logic [31:0] stat);
    for (int i = 0; i < n; i++) begin
      rx_mac_data_valid = 1'b1;
      rx_mac_data.last = (i == n - 1);
      rx_mac_data.data = base + 32'(i);
      do @(posedge clk); while (rx_mac_data_ready !== 1'b1);
      #1;
    end
    rx_mac_data_valid = 1'b0;
    rx_mac_data = ~rx_mac_data;
    rx_mac_stat_valid = 1'b1;
    rx_mac_stat = stat;
    do @(posedge clk); while (rx_mac_stat_ready !== 1'b1);
    #1;
    rx_mac_stat_valid = 1'b0;
    rx_mac_stat = ~stat;
  endtask
  // one frame on the wire, closed by its status
  task automatic tx_frame(input int len);
    if (len > 0) begin
      tx_frame_busy = 1'b1;
      repeat (len) tick();
    end
    tx_frame_busy = 1'b0;
    tx_status_push = 1'b1;
    tick();
    tx_status_push = 1'b0;
  endtask
endmodule
`default_nettype wire

/* test/host_fifo_tx_rx_control_tb.sv */
// self-checking bench for the host fifo control block
`default_nettype none
module host_fifo_tx_rx_control_tb
  import hfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n, soft_reset, tx_data_wr, tx_error_clr, tx_status_full;
  logic status_discard_on_overrun, tx_halt_set, tx_on_set, rx_data_rd;
  logic rx_stat_rd, rx_pad_enable, rx_skip_set, rx_flush_set, w;
  logic tx_status_push, tx_frame_busy, tx_error_flag, tx_on, tx_halt_req;
  logic tx_halted_irq, tx_mac_go, tx_status_wr, rx_mac_data_valid;
  logic rx_mac_data_ready, rx_mac_stat_valid, rx_mac_stat_ready;
  logic rx_error_irq, rx_skip_packet, rx_flush_busy;
  logic [LEN_W-1:0] tx_data_free;
  logic [DATA_W-1:0] rx_mac_stat, rx_data_out, rx_stat_out, b;
  logic [5:0] rx_data_used;
  logic [4:0] rx_stat_used, rx_offset, rx_burst_words;
  hfc_tx_cmd_t tx_cmd;
  hfc_rx_word_t rx_mac_data;
  int n_mismatch = 0;
  int check_count = 0;

  always #50 clk = ~clk;

  hfc_top u_hfc_top (.clk, .reset_n, .soft_reset, .tx_cmd, .tx_data_wr,
    .tx_data_free, .tx_error_clr, .status_discard_on_overrun,
    .tx_status_push, .tx_status_full, .tx_frame_busy, .tx_halt_set,
    .tx_on_set, .tx_error_flag, .tx_on, .tx_halt_req, .tx_halted_irq,
    .tx_mac_go, .tx_status_wr, .rx_mac_data_valid, .rx_mac_data,
    .rx_mac_data_ready, .rx_mac_stat_valid, .rx_mac_stat,
    .rx_mac_stat_ready, .rx_data_rd, .rx_data_out, .rx_stat_rd,
    .rx_stat_out, .rx_data_used, .rx_stat_used, .rx_error_irq,
    .rx_offset, .rx_pad_enable, .rx_burst_words, .rx_skip_set,
    .rx_skip_packet, .rx_flush_set, .rx_flush_busy);
  hfc_mac_model u_hfc_mac_model (.clk, .rx_mac_data_valid, .rx_mac_data,
    .rx_mac_data_ready, .rx_mac_stat_valid, .rx_mac_stat,
    .rx_mac_stat_ready, .tx_status_push, .tx_frame_busy);

  ////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cmd(input logic f, l, input logic [31:0] bw, input int n);
    tx_cmd = '{1'b1, f, l, bw, LEN_W'(n)};
    tick();
    tx_cmd.valid = 1'b0;
    tick();
  endtask
  // flag is sticky, so clear it before the next case
  task automatic err_is(input logic exp);
    repeat (2) tick();
    chk(tx_error_flag, exp, "tx error flag");
    pulse(tx_error_clr);
    tick();
  endtask
  task automatic rd(input logic [31:0] exp);
    pulse(rx_data_rd);
    chk(rx_data_out, exp, "rx data");
    tick();
  endtask
  task automatic rds(input logic [31:0] exp);
    pulse(rx_stat_rd);
    chk(rx_stat_out, exp, "rx status");
    tick();
  endtask
  // byte offset of one: each word moves up a byte, top byte carries
  function automatic logic [31:0] sh(input logic [31:0] cur, prev);
    return (cur << 8) | (prev >> 24);
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, soft_reset, tx_data_wr, tx_error_clr, tx_status_full} = '0;
    {status_discard_on_overrun, tx_halt_set, tx_on_set, rx_data_rd} = '0;
    {rx_stat_rd, rx_pad_enable, rx_skip_set, rx_flush_set} = '0;
    {rx_offset, rx_burst_words} = '0;
    tx_data_free = 11'h10;
    tx_cmd = '0;
    repeat (3) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (3) tick();
    chk({rx_mac_data_ready, rx_mac_stat_ready}, 2'h3, "ready at reset");
    chk({tx_error_flag, tx_on, tx_halted_irq, rx_error_irq}, 0, "reset");
    pulse(tx_on_set);
    chk({tx_on, tx_mac_go}, 2'h3, "tx enabled");
    tick();
    cmd(1'b1, 1'b0, 32'h6, 2);
    cmd(1'b0, 1'b1, 32'h6, 4);
    err_is(1'b0);
    cmd(1'b1, 1'b1, 32'h6, 5);
    err_is(1'b1);
    cmd(1'b1, 1'b0, 32'h10006, 2);
    cmd(1'b0, 1'b1, 32'h20006, 4);
    err_is(1'b1);
    pulse(tx_data_wr);
    err_is(1'b0);
    tx_data_free = '0;
    pulse(tx_data_wr);
    err_is(1'b1);
    chk({tx_on, tx_mac_go}, 2'h3, "runs on error");
    for (int k = 0; k < 3; k++) begin
      tx_status_full = (k > 0);
      status_discard_on_overrun = (k == 2);
      tick();
      chk(tx_mac_go, k != 1, "go vs status room");
      u_hfc_mac_model.tx_frame(0);
      w = tx_status_wr;
      tick();
      w = w | tx_status_wr;
      chk(w, k == 0, "status written");
      err_is(k == 1);
    end
    {tx_status_full, status_discard_on_overrun} = 2'h0;
    fork
      u_hfc_mac_model.tx_frame(6);
      begin
        tick();
        pulse(tx_halt_set);
        chk({tx_halt_req, tx_on}, 2'h3, "halt pending");
      end
    join
    chk(tx_halted_irq, 1, "halt irq");
    chk({tx_on, tx_halt_req, tx_mac_go}, 0, "stopped");
    tick();
    chk(tx_halted_irq, 0, "irq one cycle");
    pulse(tx_on_set);
    chk(tx_on, 1, "restart");
    tick();
    pulse(tx_halt_set);
    chk({tx_halted_irq, tx_on}, 2'h2, "idle halt");
    rx_offset = 5'h4;
    u_hfc_mac_model.send_pkt(4, 32'h100, 32'h55);
    u_hfc_mac_model.send_pkt(2, 32'h200, 32'h66);
    repeat (2) tick();
    chk(rx_data_used, 6'h6, "data queued");
    chk(rx_stat_used, 5'h2, "status queued");
    pulse(rx_skip_set);
    chk(rx_skip_packet, 1, "skip busy");
    repeat (8) tick();
    chk(rx_skip_packet, 0, "skip done");
    chk({rx_data_used, rx_stat_used}, {6'h2, 5'h2}, "skipped");
    rds(32'h55);
    rds(32'h66);
    rd(32'h0);
    rd(32'h200);
    rd(32'h201);
    rx_offset = 5'h5;
    for (int p = 1; p < 3; p++)
      u_hfc_mac_model.send_pkt(2, 32'h11223344 * p, 32'h0);
    repeat (2) tick();
    for (int p = 1; p < 3; p++) begin
      b = 32'h11223344 * p;
      rd(32'h0);
      rd(sh(b, 32'h0));
      rd(sh(b + 1, b));
      rd(sh(32'h0, b + 1));
    end
    rx_offset = 5'h0;
    {rx_pad_enable, rx_burst_words} = {1'b1, 5'h4};
    u_hfc_mac_model.send_pkt(3, 32'hab00, 32'h0);
    repeat (2) tick();
    for (int i = 0; i < 4; i++)
      rd(i < 3 ? 32'hab00 + i : 32'h0);
    rx_pad_enable = 1'b0;
    u_hfc_mac_model.send_pkt(3, 32'h0, 32'h0);
    pulse(rx_flush_set);
    chk(rx_flush_busy, 1, "flush busy");
    tick();
    chk(rx_flush_busy, 0, "flush done");
    tick();
    chk({rx_data_used, rx_stat_used}, 11'h0, "flushed");
    u_hfc_mac_model.send_pkt(32, 32'hf00, 32'h1);
    tick();
    chk({rx_mac_data_ready, rx_data_used}, 7'h20, "fifo full");
    for (int i = 0; i < 32; i++)
      rd(32'hf00 + i);
    chk({rx_mac_data_ready, rx_data_used}, 7'h40, "drained");
    // data underrun first, then status underrun once soft reset emptied it
    for (int u = 0; u < 2; u++) begin
      chk(rx_stat_used, u == 0, "status left");
      if (u == 0) pulse(rx_data_rd);
      else pulse(rx_stat_rd);
      tick();
      chk(rx_error_irq, 1, "underrun");
      pulse(soft_reset);
      tick();
      chk(rx_error_irq, 0, "soft reset");
    end
    conclude();
  end

  initial begin
    #2000000;
    n_mismatch++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end
endmodule
`default_nettype wire
